// *** opc_far_model.sv ***
// Purpose: far-side sync source and stream feeder
// Assumes: the block samples the sync pins with its own clock
// Notes:   link clock stands still outside a sync frame
`timescale 1ns/100ps
`default_nettype none
module opc_far_model (
	// towards the block
	output logic [1:0] pin_sync_out,
	output logic [31:0] raw_out,
	output logic [31:0] gl_out
);
	logic link_clk = 1'b0;
	initial begin
		pin_sync_out = 2'b00;
		raw_out = 32'h0;
		gl_out = 32'hffffffff;
	end
	// samples move on every beat so no stale value survives
	always @(posedge link_clk) begin
		raw_out <= raw_out + 32'h00030007;
		gl_out <= ~raw_out;
	end
	// one framed sync pulse on pin g, high for the first of two link beats
	task send_sync(input int g);
		for (int i = 0; i < 2; i++) begin
			pin_sync_out[g] = (i == 0);
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
	endtask
endmodule // opc_far_model
`default_nettype wire

// *** opc_map.vh ***
// Purpose: register indices, field positions and reset values for the
//          output port and gain loop control block
// Assumes: indices are channel address pointer values
// Notes:   definitions only
`ifndef OPC_MAP_VH
`define OPC_MAP_VH
// register indices (channel address pointer values)
`define OPC_IDX_HB_A 8'h08
`define OPC_IDX_HB_B 8'h09
`define OPC_IDX_GL_CTL 8'h0a
`define OPC_IDX_GL_HOLD 8'h0b
`define OPC_IDX_PAR_A 8'h1a
`define OPC_IDX_LINK_A 8'h1b
`define OPC_IDX_PAR_B 8'h1c
`define OPC_IDX_LINK_B 8'h1d
`define OPC_IDX_CLK 8'h1e
// microport addresses and sleep access enable bit
`define OPC_SLEEP_ADDR 3'h3
`define OPC_PTR_ADDR 3'h6
`define OPC_DATA_ADDR 3'h7
`define OPC_SLEEP_ACC_BIT 5
// gain loop control fields
`define OPC_GL_WL_HI 7
`define OPC_GL_WL_LO 5
`define OPC_GL_CLIP_BIT 4
`define OPC_GL_SYNC_BIT 3
`define OPC_GL_INIT_BIT 2
`define OPC_GL_FIRST_BIT 1
`define OPC_GL_BYP_BIT 0
// parallel and link port fields
`define OPC_PAR_FMT_BIT 5
`define OPC_SRC_BIT 0
`define OPC_LNK_EN_BIT 7
`define OPC_LNK_WAIT_HI 6
`define OPC_LNK_WAIT_LO 3
`define OPC_LNK_NORSSI_BIT 2
`define OPC_LNK_2CH_BIT 1
// reset values
`define OPC_RST_8 8'h00
`define OPC_RST_16 16'h0000
`define OPC_RST_CLK 3'h0
`endif

// *** opc_regmem.v ***
// Purpose: small two-bank register store, registered read data
// Assumes: at most one write and one read per cycle
// Notes:   bank bit selects lower or upper unit group
`timescale 1ns/100ps
`default_nettype none
module opc_regmem #(
	parameter AW = 6,
	parameter DW = 8
) (
	// clock
	input wire core_clk_in,
	// write port
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	// read port
	input wire [AW-1:0] rd_addr_in,
	output reg [DW-1:0] rd_data_out
);
	reg [DW-1:0] mem_q [0:(1<<AW)-1];
	// registered read keeps the read path short
	always @(posedge core_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule // opc_regmem
`default_nettype wire

// *** opc_top.v ***
// Function
// - upper select addresses upper unit group
// - filter A interleaves 0..3; bit0 bypasses
// - bypass still interleaves, no interpolation
// - filter B serves channels 2/3; bypassable
// - control bits 7-5 pick word length
// - length code 111=4 down to 000=16
// - bit4 selects level or clipping tracking
// - sync loads holdoff, count down, update
// - soft/pin sync reload; 0 disables
// - bit3 gives immediate host sync
// - init-on-sync clears filter, reloads params
// - without init, update only, no clear
// - first-sync-only ignores later syncs
// - bypass passes 16 msbs, 8-bit truncates
// - parallel format bit and channel enables
// - bit0 picks gain loop or channel source
// - link enable and wait field
// - link bit2 suppresses strength word
// - link bit1 selects two-channel mode
// - clock divisor, master bit, boots slave
//
// Purpose: output port and gain loop control for two unit groups
// Assumes: microport strobes and pin sync are asynchronous to the core
// Notes:   loop arithmetic lives downstream; this block issues controls
`timescale 1ns/100ps
`default_nettype none
`include "opc_map.vh"
module opc_top #(
	parameter HOLD_W = 16
) (
	// clock and reset
	input wire core_clk_in,
	input wire reset_n_in,
	// microport
	input wire lower_group_select_n_in,
	input wire upper_group_select_n_in,
	input wire wr_n_in,
	input wire rd_n_in,
	input wire [2:0] addr_in,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output wire data_oe_out,
	// external sync pins, one per group
	input wire [1:0] pin_sync_in,
	// stream data from rate filters, per group, two channels
	input wire [31:0] rate_filter_output_in,
	input wire [31:0] gain_data_in,
	// gain loop controls per group
	output reg [1:0] gl_update_out,
	output reg [1:0] gl_init_out,
	output reg [7:0] gl_width_out,
	output reg [1:0] gl_clip_mode_out,
	output reg [1:0] gl_bypass_out,
	// half-band filter controls per group
	output reg [1:0] hb_a_bypass_out,
	output reg [3:0] hb_a_chans_out,
	output reg [1:0] hb_b_bypass_out,
	output reg [1:0] hb_b_chans_out,
	// output port controls per group
	output reg [31:0] port_data_out,
	output reg [3:0] par_8bit_out,
	output reg [15:0] par_chan_en_out,
	output reg [3:0] link_en_out,
	output reg [15:0] link_wait_out,
	output reg [3:0] link_rssi_en_out,
	output reg [3:0] link_2ch_out,
	output reg [1:0] clk_master_out,
	output reg [3:0] clk_div_out
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg [14:0] pin_s1_q;
	reg [14:0] pin_s2_q;
	reg [14:0] pin_s3_q;
	wire [14:0] pin_raw;
	assign pin_raw = {pin_sync_in, lower_group_select_n_in,
		upper_group_select_n_in, wr_n_in, rd_n_in, addr_in, data_in[5:0]};
	// data top two bits synchronised separately below
	reg [1:0] dhi_s1_q;
	reg [1:0] dhi_s2_q;
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			pin_s1_q <= 15'h7fff;
			pin_s2_q <= 15'h7fff;
			pin_s3_q <= 15'h7fff;
			dhi_s1_q <= 2'h0;
			dhi_s2_q <= 2'h0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			dhi_s1_q <= data_in[7:6];
			dhi_s2_q <= dhi_s1_q;
		end
	end
	wire [1:0] psync = pin_s2_q[14:13];
	wire [1:0] psync_p = pin_s3_q[14:13];
	wire cs0_n = pin_s2_q[12];
	wire cs1_n = pin_s2_q[11];
	wire wr_n = pin_s2_q[10];
	wire wr_n_p = pin_s3_q[10];
	wire rd_n = pin_s2_q[9];
	wire [2:0] addr = pin_s2_q[8:6];
	wire [7:0] wdat = {dhi_s2_q, pin_s2_q[5:0]};
	// write taken on rising edge of the write strobe
	wire wr_evt = wr_n & ~wr_n_p & (~cs0_n | ~cs1_n);
	wire bank = cs0_n;
	////////////////////////////////////////////////////////////////////
	// sleep access bit and pointer per bank
	reg [1:0] acc_q;
	reg [7:0] ptr0_q;
	reg [7:0] ptr1_q;
	wire [7:0] ptr = bank ? ptr1_q : ptr0_q;
	wire reg_wr = wr_evt & (addr == `OPC_DATA_ADDR) & acc_q[bank];
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			acc_q <= 2'h0;
			ptr0_q <= `OPC_RST_8;
			ptr1_q <= `OPC_RST_8;
		end else if (wr_evt) begin
			if (addr == `OPC_SLEEP_ADDR) begin
				acc_q[bank] <= wdat[`OPC_SLEEP_ACC_BIT];
			end
			if (addr == `OPC_PTR_ADDR && !bank) begin
				ptr0_q <= wdat;
			end
			if (addr == `OPC_PTR_ADDR && bank) begin
				ptr1_q <= wdat;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// control registers, two banks each
	reg [7:0] hb_a_q [0:1];
	reg [7:0] hb_b_q [0:1];
	reg [7:0] glc_q [0:1];
	reg [15:0] hold_q [0:1];
	reg [7:0] par_a_q [0:1];
	reg [7:0] lnk_a_q [0:1];
	reg [7:0] par_b_q [0:1];
	reg [7:0] lnk_b_q [0:1];
	reg [2:0] clk_q [0:1];
	reg [1:0] sync_cmd_q; // one-cycle host sync pulse
	// unmapped indices land in the plain store
	wire [6:0] mem_rd;
	wire [7:0] mem_q;
	opc_regmem #(.AW(7), .DW(8)) u_mem (
		.core_clk_in(core_clk_in),
		.wr_en_in(reg_wr),
		.wr_addr_in({bank, ptr[5:0]}),
		.wr_data_in(wdat),
		.rd_addr_in(mem_rd),
		.rd_data_out(mem_q)
	);
	assign mem_rd = {bank, ptr[5:0]};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_bank
			wire sel = reg_wr & (bank == g);
			always @(posedge core_clk_in) begin
				if (!reset_n_in) begin
					hb_a_q[g] <= `OPC_RST_8;
					hb_b_q[g] <= `OPC_RST_8;
					glc_q[g] <= `OPC_RST_8;
					hold_q[g] <= `OPC_RST_16;
					par_a_q[g] <= `OPC_RST_8;
					lnk_a_q[g] <= `OPC_RST_8;
					par_b_q[g] <= `OPC_RST_8;
					lnk_b_q[g] <= `OPC_RST_8;
					clk_q[g] <= `OPC_RST_CLK;
					sync_cmd_q[g] <= 1'b0;
				end else begin
					sync_cmd_q[g] <= sel && ptr == `OPC_IDX_GL_CTL &&
						wdat[`OPC_GL_SYNC_BIT];
					if (sel) begin
						case (ptr)
						`OPC_IDX_HB_A: hb_a_q[g] <= {5'h00, wdat[2:0]};
						`OPC_IDX_HB_B: hb_b_q[g] <= {5'h00, wdat[2:0]};
						`OPC_IDX_GL_CTL: glc_q[g] <= wdat;
						`OPC_IDX_GL_HOLD: hold_q[g] <= {hold_q[g][7:0], wdat};
						`OPC_IDX_PAR_A: par_a_q[g] <= {2'h0, wdat[5:0]};
						`OPC_IDX_LINK_A: lnk_a_q[g] <= wdat;
						`OPC_IDX_PAR_B: par_b_q[g] <= {2'h0, wdat[5:0]};
						`OPC_IDX_LINK_B: lnk_b_q[g] <= wdat;
						`OPC_IDX_CLK: clk_q[g] <= wdat[2:0];
						default: ;
						endcase
					end
				end
			end
			////////////////////////////////////////////////////////////
			// sync and holdoff engine
			reg [15:0] cnt_q;
			reg run_q;
			reg seen_q;
			wire any_sync = sync_cmd_q[g] | (psync[g] & ~psync_p[g]);
			wire first_only = glc_q[g][`OPC_GL_FIRST_BIT];
			wire accept = any_sync & (hold_q[g] != 16'h0000) &
				~(first_only & seen_q);
			wire fire = (accept & hold_q[g] == 16'h0001) |
				(run_q & cnt_q == 16'h0002);
			always @(posedge core_clk_in) begin
				if (!reset_n_in) begin
					cnt_q <= `OPC_RST_16;
					run_q <= 1'b0;
					seen_q <= 1'b0;
					gl_update_out[g] <= 1'b0;
					gl_init_out[g] <= 1'b0;
				end else begin
					gl_update_out[g] <= fire;
					gl_init_out[g] <= fire & glc_q[g][`OPC_GL_INIT_BIT];
					if (accept) begin
						seen_q <= 1'b1;
						cnt_q <= hold_q[g];
						run_q <= hold_q[g] > 16'h0001;
					end else if (run_q) begin
						cnt_q <= cnt_q - 16'h0001;
						run_q <= cnt_q > 16'h0002;
					end
					if (!first_only) begin
						seen_q <= 1'b0;
					end
				end
			end
			////////////////////////////////////////////////////////////
			// field decode to outputs
			always @(posedge core_clk_in) begin
				if (!reset_n_in) begin
					gl_width_out[g*4+:4] <= 4'h0;
					gl_clip_mode_out[g] <= 1'b0;
					gl_bypass_out[g] <= 1'b0;
					hb_a_bypass_out[g] <= 1'b0;
					hb_a_chans_out[g*2+:2] <= 2'h0;
					hb_b_bypass_out[g] <= 1'b0;
					hb_b_chans_out[g] <= 1'b0;
					par_8bit_out[g*2+:2] <= 2'h0;
					par_chan_en_out[g*8+:8] <= 8'h00;
					link_en_out[g*2+:2] <= 2'h0;
					link_wait_out[g*8+:8] <= 8'h00;
					link_rssi_en_out[g*2+:2] <= 2'h0;
					link_2ch_out[g*2+:2] <= 2'h0;
					clk_master_out[g] <= 1'b0;
					clk_div_out[g*2+:2] <= 2'h0;
					port_data_out[g*16+:16] <= 16'h0000;
				end else begin
					gl_width_out[g*4+:4] <= wl_bits(glc_q[g][7:5]);
					gl_clip_mode_out[g] <= glc_q[g][`OPC_GL_CLIP_BIT];
					gl_bypass_out[g] <= glc_q[g][`OPC_GL_BYP_BIT];
					// bypass keeps interleave; only filtering is skipped
					hb_a_bypass_out[g] <= hb_a_q[g][0];
					hb_a_chans_out[g*2+:2] <= hb_a_q[g][2:1];
					hb_b_bypass_out[g] <= hb_b_q[g][0];
					hb_b_chans_out[g] <= hb_b_q[g][1];
					par_8bit_out[g*2] <= par_a_q[g][`OPC_PAR_FMT_BIT];
					par_8bit_out[g*2+1] <= par_b_q[g][`OPC_PAR_FMT_BIT];
					par_chan_en_out[g*8+:8] <= {par_b_q[g][4:1],
						par_a_q[g][4:1]};
					link_en_out[g*2] <= lnk_a_q[g][`OPC_LNK_EN_BIT];
					link_en_out[g*2+1] <= lnk_b_q[g][`OPC_LNK_EN_BIT];
					link_wait_out[g*8+:8] <= {lnk_b_q[g][6:3], lnk_a_q[g][6:3]};
					link_rssi_en_out[g*2] <= ~lnk_a_q[g][`OPC_LNK_NORSSI_BIT];
					link_rssi_en_out[g*2+1] <= ~lnk_b_q[g][`OPC_LNK_NORSSI_BIT];
					link_2ch_out[g*2] <= lnk_a_q[g][`OPC_LNK_2CH_BIT];
					link_2ch_out[g*2+1] <= lnk_b_q[g][`OPC_LNK_2CH_BIT];
					clk_master_out[g] <= clk_q[g][0];
					clk_div_out[g*2+:2] <= clk_q[g][2:1];
					port_data_out[g*16+:16] <= src_word(par_a_q[g][`OPC_SRC_BIT],
						glc_q[g][`OPC_GL_BYP_BIT], par_a_q[g][`OPC_PAR_FMT_BIT],
						rate_filter_output_in[g*16+:16],
						gain_data_in[g*16+:16]);
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// word length decode: 111=4 ... 000=16
	function [3:0] wl_bits;
		input [2:0] code;
		begin
			case (code)
			3'h7: wl_bits = 4'h4;
			3'h6: wl_bits = 4'h5;
			3'h5: wl_bits = 4'h6;
			3'h4: wl_bits = 4'h7;
			3'h3: wl_bits = 4'h8;
			3'h2: wl_bits = 4'ha;
			3'h1: wl_bits = 4'hc;
			default: wl_bits = 4'h0; // 0 stands for 16 bits
			endcase
		end
	endfunction
	// source select; bypassed loop passes raw 16 msbs
	function [15:0] src_word;
		input from_gl;
		input gl_byp;
		input fmt8;
		input [15:0] chan;
		input [15:0] gl;
		reg [15:0] w;
		begin
			w = (from_gl && !gl_byp) ? gl : chan;
			src_word = fmt8 ? {w[15:8], 8'h00} : w;
		end
	endfunction
	////////////////////////////////////////////////////////////////////
	// readback; bank picks which group answers
	reg [7:0] rd_d;
	always @* begin
		case (ptr)
		`OPC_IDX_HB_A: rd_d = hb_a_q[bank];
		`OPC_IDX_HB_B: rd_d = hb_b_q[bank];
		`OPC_IDX_GL_CTL: rd_d = glc_q[bank];
		`OPC_IDX_GL_HOLD: rd_d = hold_q[bank][7:0];
		`OPC_IDX_PAR_A: rd_d = par_a_q[bank];
		`OPC_IDX_LINK_A: rd_d = lnk_a_q[bank];
		`OPC_IDX_PAR_B: rd_d = par_b_q[bank];
		`OPC_IDX_LINK_B: rd_d = lnk_b_q[bank];
		`OPC_IDX_CLK: rd_d = {5'h00, clk_q[bank]};
		default: rd_d = mem_q;
		endcase
	end
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			data_out <= 8'h00;
		end else if (addr == `OPC_PTR_ADDR) begin
			data_out <= ptr;
		end else begin
			data_out <= acc_q[bank] ? rd_d : 8'h00;
		end
	end
	// drive bus while a selected read is active
	assign data_oe_out = ~rd_n & (~cs0_n | ~cs1_n);
endmodule // opc_top
`default_nettype wire

// *** opc_top_props.sv ***
// Purpose: port checks for opc_top
// Assumes: synchronous active-low reset, one core clock
// Notes:   bound into every opc_top instance
`timescale 1ns/100ps
`default_nettype none
module opc_top_props (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// microport strobe
	input wire logic wr_n_in,
	// watched outputs
	input wire logic [1:0] gl_update_out,
	input wire logic [1:0] gl_init_out,
	input wire logic [7:0] gl_width_out,
	input wire logic [1:0] hb_a_bypass_out,
	input wire logic [3:0] link_en_out,
	input wire logic [15:0] link_wait_out,
	input wire logic [1:0] clk_master_out,
	input wire logic [3:0] clk_div_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [3:0] idle_q;
	////////////////////////////////////////////////////////////////////
	// quiet time since the last write strobe; writes land late
	always @(posedge core_clk_in) begin
		if (!reset_n_in || !wr_n_in)
			idle_q <= 4'h0;
		else if (idle_q != 4'hf)
			idle_q <= idle_q + 4'h1;
	end
	////////////////////////////////////////////////////////////////////
	property p_init_g0; gl_init_out[0] |-> gl_update_out[0]; endproperty
	a_init_g0: assert property (p_init_g0)
		else $error("group 0 init without update");
	property p_init_g1; gl_init_out[1] |-> gl_update_out[1]; endproperty
	a_init_g1: assert property (p_init_g1)
		else $error("group 1 init without update");
	property p_pulse_g0; gl_update_out[0] |=> !gl_update_out[0]; endproperty
	a_pulse_g0: assert property (p_pulse_g0)
		else $error("group 0 update longer than one cycle");
	property p_pulse_g1; gl_update_out[1] |=> !gl_update_out[1]; endproperty
	a_pulse_g1: assert property (p_pulse_g1)
		else $error("group 1 update longer than one cycle");
	property p_cfg_hold; idle_q == 4'hf |-> $stable({hb_a_bypass_out,
		link_en_out, link_wait_out, clk_master_out, clk_div_out});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("control level moved without a write");
	property p_width_g0; gl_width_out[3:0] inside {4'h0, 4'h4, 4'h5,
		4'h6, 4'h7, 4'h8, 4'ha, 4'hc}; endproperty
	a_width_g0: assert property (p_width_g0)
		else $error("group 0 word length off the table");
	property p_width_g1; gl_width_out[7:4] inside {4'h0, 4'h4, 4'h5,
		4'h6, 4'h7, 4'h8, 4'ha, 4'hc}; endproperty
	a_width_g1: assert property (p_width_g1)
		else $error("group 1 word length off the table");
	property p_boot; $rose(reset_n_in) |->
		clk_master_out == 2'b00 && clk_div_out == 4'h0; endproperty
	a_boot: assert property (p_boot)
		else $error("port clock not slave after reset");
endmodule // opc_top_props
bind opc_top opc_top_props i_opc_top_props (.core_clk_in(core_clk_in),
	.reset_n_in(reset_n_in), .wr_n_in(wr_n_in),
	.gl_update_out(gl_update_out), .gl_init_out(gl_init_out),
	.gl_width_out(gl_width_out), .hb_a_bypass_out(hb_a_bypass_out),
	.link_en_out(link_en_out), .link_wait_out(link_wait_out),
	.clk_master_out(clk_master_out), .clk_div_out(clk_div_out));
`default_nettype wire

// *** test_output_port_agc_control.sv ***
// Purpose: self-checking bench for opc_top
// Assumes: access bit and pointer are written before data
// Notes:   expectations come from a byte model of both banks
`timescale 1ns/100ps
`default_nettype none
module test_output_port_agc_control;
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic lsel_n = 1'b1, usel_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, ini;
	logic [2:0] addr = 3'h0;
	logic [7:0] din = 8'h00, rdata;
	wire [7:0] data_out, width;
	wire [1:0] psync, upd, init, clip, glbyp, hba, hbb, hbbc, mst;
	wire [3:0] hbac, p8, len, rsen, l2, div;
	wire [15:0] pen, lwait;
	wire [31:0] raw, gld, pdat;
	wire oe;
	int miscompares = 0, num_checks = 0, seed = 91, upd0 = 0, a, b, n;
	logic [7:0] mdl [2][32];
	logic [3:0] wl [8] = '{4'h0, 4'hc, 4'ha, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4};
	logic [7:0] ri [8] = '{8'h08, 8'h09, 8'h0a, 8'h1a, 8'h1b, 8'h1c,
		8'h1d, 8'h1e};
	logic [7:0] mk [8] = '{8'h07, 8'h07, 8'hf7, 8'h3f, 8'hff, 8'h3f,
		8'hff, 8'h07};
	always #5 core_clk_in = ~core_clk_in;
	// tally group 0 update pulses
	always @(posedge core_clk_in) if (upd[0] === 1'b1) upd0++;
	////////////////////////////////////////////////////////////////////
	opc_top i_opc_top (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.lower_group_select_n_in(lsel_n), .upper_group_select_n_in(usel_n),
		.wr_n_in(wr_n), .rd_n_in(rd_n), .addr_in(addr), .data_in(din),
		.data_out(data_out), .data_oe_out(oe), .pin_sync_in(psync),
		.rate_filter_output_in(raw), .gain_data_in(gld),
		.gl_update_out(upd), .gl_init_out(init), .gl_width_out(width),
		.gl_clip_mode_out(clip), .gl_bypass_out(glbyp),
		.hb_a_bypass_out(hba), .hb_a_chans_out(hbac),
		.hb_b_bypass_out(hbb), .hb_b_chans_out(hbbc), .port_data_out(pdat),
		.par_8bit_out(p8), .par_chan_en_out(pen), .link_en_out(len),
		.link_wait_out(lwait), .link_rssi_en_out(rsen), .link_2ch_out(l2),
		.clk_master_out(mst), .clk_div_out(div));
	opc_far_model i_opc_far_model (.pin_sync_out(psync), .raw_out(raw),
		.gl_out(gld));
	////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// strobes held six clocks each level, well past the synchroniser
	task bus(input int g, input logic [2:0] ad, input logic [7:0] d,
		input logic rd);
		@(posedge core_clk_in);
		lsel_n <= (g != 0);
		usel_n <= (g == 0);
		addr <= ad;
		din <= d;
		if (rd) rd_n <= 1'b0;
		else wr_n <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		rdata = data_out;
		if (rd) chk(oe, 1'b1);
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		lsel_n <= 1'b1;
		usel_n <= 1'b1;
	endtask
	task prog(input int g, input logic [7:0] i, input logic [7:0] v);
		bus(g, 3'h6, i, 1'b0);
		bus(g, 3'h7, v, 1'b0);
		mdl[g][i] = v;
	endtask
	task rdb(input int g, input logic [7:0] i);
		bus(g, 3'h6, i, 1'b0);
		bus(g, 3'h7, 8'h00, 1'b1);
		chk(rdata, mdl[g][i]);
	endtask
	// holdoff value goes in high byte first
	task hold(input int g, input logic [15:0] v);
		bus(g, 3'h6, 8'h0b, 1'b0);
		bus(g, 3'h7, v[15:8], 1'b0);
		bus(g, 3'h7, v[7:0], 1'b0);
	endtask
	// cycles from a far-side sync to the update pulse, -1 if none
	task lat(input int g, output int r);
		r = -1;
		#2;
		fork
			i_opc_far_model.send_sync(g);
		join_none
		for (int i = 0; i < 60; i++) begin
			@(posedge core_clk_in);
			#1;
			if (upd[g] === 1'b1 && r < 0) begin
				r = i;
				ini = init[g];
			end
		end
	endtask
	task check_outs;
		logic [15:0] w, e;
		for (int g = 0; g < 2; g++) begin
			// port word from the rules: source pick, then 8-bit cut
			w = (mdl[g][26][0] && !mdl[g][10][0]) ? gld[g*16+:16] :
				raw[g*16+:16];
			e = mdl[g][26][5] ? {w[15:8], 8'h00} : w;
			chk(pdat[g*16+:16], e);
			chk({hba[g], hbac[g*2+:2], hbb[g], hbbc[g]}, {mdl[g][8][0],
				mdl[g][8][2:1], mdl[g][9][0], mdl[g][9][1]});
			chk({width[g*4+:4], clip[g], glbyp[g]}, {wl[mdl[g][10][7:5]],
				mdl[g][10][4], mdl[g][10][0]});
			chk({p8[g*2+:2], pen[g*8+:8]}, {mdl[g][28][5], mdl[g][26][5],
				mdl[g][28][4:1], mdl[g][26][4:1]});
			chk({len[g*2+:2], lwait[g*8+:8]}, {mdl[g][29][7], mdl[g][27][7],
				mdl[g][29][6:3], mdl[g][27][6:3]});
			chk({rsen[g*2+:2], l2[g*2+:2]}, {~mdl[g][29][2], ~mdl[g][27][2],
				mdl[g][29][1], mdl[g][27][1]});
			chk({mst[g], div[g*2+:2]}, {mdl[g][30][0],
				mdl[g][30][2:1]});
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		for (int g = 0; g < 2; g++)
			for (int i = 0; i < 32; i++)
				mdl[g][i] = 8'h00;
		repeat (20) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		check_outs();
		// holdoff boots at zero, so a pin sync must not update
		lat(0, n);
		chk(n, -1);
		prog(0, 8'h0a, 8'h01);
		mdl[0][10] = 8'h00;
		check_outs();
		bus(0, 3'h3, 8'h20, 1'b0);
		bus(1, 3'h3, 8'h20, 1'b0);
		repeat (2)
			for (int g = 0; g < 2; g++)
				for (int r = 0; r < 8; r++) begin
					prog(g, ri[r], 8'($random(seed)) & mk[r]);
					rdb(g, ri[r]);
					check_outs();
				end
		for (int c = 0; c < 8; c++) begin
			prog(0, 8'h0a, 8'(c << 5));
			check_outs();
		end
		prog(0, 8'h0a, 8'h04);
		hold(0, 16'h0003);
		lat(0, a);
		chk(ini, 1'b1);
		prog(0, 8'h0a, 8'h00);
		hold(0, 16'h0007);
		lat(0, b);
		chk(ini, 1'b0);
		chk(b - a, 4);
		hold(0, 16'h0001);
		lat(0, n);
		chk(a - n, 2);
		if (a < 0 || b < 0 || n < 0) miscompares++;
		hold(0, 16'h0000);
		n = upd0;
		lat(0, b);
		chk(upd0 - n, 0);
		prog(1, 8'h0a, 8'h04);
		hold(1, 16'h0003);
		lat(1, b);
		chk(b, a);
		chk(ini, 1'b1);
		hold(0, 16'h0003);
		prog(0, 8'h0a, 8'h02);
		n = upd0;
		lat(0, b);
		lat(0, b);
		chk(upd0 - n, 1);
		prog(0, 8'h0a, 8'h00);
		n = upd0;
		prog(0, 8'h0a, 8'h08);
		// the host sync lands a few clocks after the strobe rises
		repeat (8) @(posedge core_clk_in);
		chk(upd0 - n, 1);
		give_verdict();
	end
endmodule // test_output_port_agc_control
`default_nettype wire
